// ### cspv_pkg.sv
// package of constants for the card socket power and video control block
package cspv_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GEN_CTL = 8'h86;
  localparam logic [7:0] ADDR_CARD_CTL = 8'h91;
  localparam logic [7:0] ADDR_DIAG = 8'h93;
  localparam logic [7:0] ADDR_PRESENT = 8'h08;
  localparam logic [7:0] ADDR_FORCE = 8'h0C;
  localparam logic [7:0] ADDR_SOCK_CTL = 8'h10;
  localparam logic [7:0] ADDR_PWR_REQ = 8'hA0;
  localparam logic [7:0] ADDR_QUERY = 8'hA4;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SWSEL = 10;
  localparam int BIT_CARD_VIDEO = 6;
  localparam int BIT_MODEL_DIS = 0;
  localparam int BIT_VSUPPORT = 27;
  localparam int BIT_VACTIVE = 11;
  localparam int BIT_STDMODEL = 10;
  localparam int BIT_SOCK_VIDEO = 9;
  localparam int BIT_QDONE = 31;
  localparam int BIT_QBUSY = 30;
  localparam int BIT_QOVR = 29;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic RST_SWSEL = 1'b0;
  localparam logic [1:0] VCC_OFF = 2'h0;
  localparam logic [1:0] VCC_3V3 = 2'h1;
  localparam logic [1:0] VCC_5V = 2'h2;
  localparam logic [2:0] AUX_0V = 3'h0;
  localparam logic [2:0] AUX_3V3 = 3'h1;
  localparam logic [2:0] AUX_5V = 3'h2;
  localparam logic [2:0] AUX_1V8 = 3'h3;
  localparam logic [2:0] AUX_12V = 3'h4;
  localparam logic [2:0] AUX_VCC = 3'h5;
  localparam logic [2:0] AUX_HIZ = 3'h6;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int OSC_HZ = 16_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ / 2;
  localparam int QUERY_TICKS = 4;
endpackage : cspv_pkg

// ### cspv_ctl.sv
// card socket power switch encoder, media query and video pass-through control
//
// Operation
// - on media detect, drive query, sample lines
// - after query ground lines, override 5 V request
// - exactly four parallel power switch control outputs
// - select bit chooses between two switch tables
// - reset selects first table with supply off and 0 V core
// - first table encoding of supply and core
// - second table supply and program voltage encoding
// - pass-through floats card address lines A25-A4
// - lines A3-A0 stay driven in pass-through
// - video status and select outputs provided
// - select output low only when pass-through enabled
// - video outputs follow port choice truth table
// - force bit 27 sets video supported bit
// - activity bit set when either socket video enabled
// - socket control bit 10 reports standard model
// - socket control bit 9 enables video per socket
// - diagnostic bit 0 disables standard model
// - legacy and new enable bits both accepted
// - internal 16 kHz tick clocks power and query
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module cspv_ctl #(
  parameter int OSC_DIV = cspv_pkg::OSC_DIV // cycles per half 16 kHz period
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic media_present_detect_n, // media detect, low when present
  input wire logic [9:0] query_lines, // query strap inputs 10..1
  output logic query_driver, // query driver output
  output logic [9:0] query_lines_o, // query line drive value (ground)
  output logic [9:0] query_lines_oe, // query line drive enable
  input wire logic port_choice, // external port choice input
  input wire logic other_socket_video, // pass-through state of other socket
  output logic [3:0] pwr_ctl, // pwr_ctl_line3..0 to power switch
  output logic [25:0] card_addr_o, // card address outputs
  output logic [25:0] card_addr_oe, // card address enables
  input wire logic [25:0] card_addr_int, // address from internal access logic
  output logic video_path_status, // video path status
  output logic video_select_n // video select, active low
);
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic switch_type_select_q, card_video_passthru_enable_q, video_model_disable_q;
  logic video_supported_q, socket_video_enable_q;
  logic [1:0] req_vcc_q;
  logic [2:0] req_aux_q;
  logic wr_en, known;
  logic [31:0] rd_d;
  logic [31:0] rdata_q;
  logic video_on, video_active;
  logic [1:0] eff_vcc;
  logic [2:0] eff_aux;
  logic q_done_q, q_busy_q, q_ovr_q;
  logic [9:0] q_lines_q;
  logic [3:0] pwr_ctl_q;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  assign prdata = rdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_type_select_q <= cspv_pkg::RST_SWSEL;
      card_video_passthru_enable_q <= 1'b0;
      video_model_disable_q <= 1'b0;
      socket_video_enable_q <= 1'b0;
      video_supported_q <= 1'b0;
      req_vcc_q <= cspv_pkg::VCC_OFF;
      req_aux_q <= cspv_pkg::AUX_0V;
    end else if (clk_en && wr_en) begin
      case (paddr)
        cspv_pkg::ADDR_GEN_CTL: switch_type_select_q <= pwdata[cspv_pkg::BIT_SWSEL];
        cspv_pkg::ADDR_CARD_CTL: card_video_passthru_enable_q <= pwdata[cspv_pkg::BIT_CARD_VIDEO];
        cspv_pkg::ADDR_DIAG: video_model_disable_q <= pwdata[cspv_pkg::BIT_MODEL_DIS];
        cspv_pkg::ADDR_SOCK_CTL: begin
          if (!video_model_disable_q) begin
            socket_video_enable_q <= pwdata[cspv_pkg::BIT_SOCK_VIDEO];
          end
        end
        cspv_pkg::ADDR_FORCE: begin
          if (pwdata[cspv_pkg::BIT_VSUPPORT]) begin
            video_supported_q <= 1'b1;
          end
        end
        cspv_pkg::ADDR_PWR_REQ: begin
          req_vcc_q <= pwdata[1:0];
          req_aux_q <= pwdata[6:4];
        end
        default: ;
      endcase
    end
  end

  // legacy bit always works; new bit only while the standard model is on
  assign video_on = card_video_passthru_enable_q || (socket_video_enable_q && !video_model_disable_q);
  assign video_active = video_on || other_socket_video;

  always_comb begin
    known = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr)
      cspv_pkg::ADDR_GEN_CTL: rd_d[cspv_pkg::BIT_SWSEL] = switch_type_select_q;
      cspv_pkg::ADDR_CARD_CTL: rd_d[cspv_pkg::BIT_CARD_VIDEO] = card_video_passthru_enable_q;
      cspv_pkg::ADDR_DIAG: rd_d[cspv_pkg::BIT_MODEL_DIS] = video_model_disable_q;
      cspv_pkg::ADDR_PRESENT: rd_d[cspv_pkg::BIT_VSUPPORT] = video_supported_q;
      cspv_pkg::ADDR_FORCE: rd_d = 32'h0000_0000;
      cspv_pkg::ADDR_SOCK_CTL: begin
        rd_d[cspv_pkg::BIT_VACTIVE] = video_active;
        rd_d[cspv_pkg::BIT_STDMODEL] = !video_model_disable_q;
        rd_d[cspv_pkg::BIT_SOCK_VIDEO] = socket_video_enable_q;
      end
      cspv_pkg::ADDR_PWR_REQ: begin
        rd_d[1:0] = req_vcc_q;
        rd_d[6:4] = req_aux_q;
      end
      cspv_pkg::ADDR_QUERY: begin
        rd_d[9:0] = q_lines_q;
        rd_d[cspv_pkg::BIT_QDONE] = q_done_q;
        rd_d[cspv_pkg::BIT_QBUSY] = q_busy_q;
        rd_d[cspv_pkg::BIT_QOVR] = q_ovr_q;
      end
      default: known = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      rdata_q <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // slow tick standing in for the 16 kHz ring oscillator
  // ----------------------------------------------------------------
  logic [15:0] div_q;
  logic osc_q, tick;
  // gated by the enable so a frozen divider cannot present a stale tick
  assign tick = clk_en && (div_q == 16'(OSC_DIV - 1)) && osc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
      osc_q <= 1'b0;
    end else if (clk_en) begin
      if (div_q == 16'(OSC_DIV - 1)) begin
        div_q <= 16'h0000;
        osc_q <= !osc_q;
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // media query sequence
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSPV_IDLE = 3'b001,
    CSPV_QUERY = 3'b010,
    CSPV_DONE = 3'b100
  } cspv_state_t;
  cspv_state_t st_q;
  logic [2:0] qcnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= CSPV_IDLE;
      qcnt_q <= 3'h0;
      q_lines_q <= 10'h000;
      q_done_q <= 1'b0;
    end else if (clk_en) begin
      case (st_q)
        CSPV_IDLE: begin
          qcnt_q <= 3'h0;
          if (!media_present_detect_n) begin
            st_q <= CSPV_QUERY;
          end
        end
        CSPV_QUERY: begin
          if (media_present_detect_n) begin
            st_q <= CSPV_IDLE;
          end else if (tick) begin
            // let strapped lines settle for a few slow ticks before sampling
            if (qcnt_q == 3'(cspv_pkg::QUERY_TICKS - 1)) begin
              q_lines_q <= query_lines;
              q_done_q <= 1'b1;
              st_q <= CSPV_DONE;
            end else begin
              qcnt_q <= qcnt_q + 3'h1;
            end
          end
        end
        CSPV_DONE: begin
          if (media_present_detect_n) begin
            q_done_q <= 1'b0;
            st_q <= CSPV_IDLE;
          end
        end
        default: st_q <= CSPV_IDLE;
      endcase
    end
  end

  assign q_busy_q = (st_q == CSPV_QUERY);
  assign query_driver = (st_q == CSPV_QUERY);
  assign query_lines_o = 10'h000;
  assign query_lines_oe = (st_q == CSPV_DONE) ? 10'h3FF : 10'h000;

  // ----------------------------------------------------------------
  // power request resolution and switch encoding
  // ----------------------------------------------------------------
  always_comb begin
    eff_vcc = req_vcc_q;
    eff_aux = req_aux_q;
    q_ovr_q = 1'b0;
    // a 5 V request on a queried media card takes the queried voltages
    if (q_done_q && req_vcc_q == cspv_pkg::VCC_5V) begin
      q_ovr_q = 1'b1;
      case (q_lines_q[1:0])
        2'h0: begin
          eff_vcc = cspv_pkg::VCC_3V3;
          eff_aux = cspv_pkg::AUX_1V8;
        end
        2'h1: begin
          eff_vcc = cspv_pkg::VCC_5V;
          eff_aux = cspv_pkg::AUX_3V3;
        end
        default: begin
          eff_vcc = cspv_pkg::VCC_OFF;
          eff_aux = cspv_pkg::AUX_0V;
        end
      endcase
    end
  end

  function automatic logic [3:0] cspv_enc(input logic sel, input logic [1:0] vcc, input logic [2:0] aux);
    logic [1:0] v;
    logic [1:0] a;
    v = (vcc == cspv_pkg::VCC_3V3) ? 2'b10 : (vcc == cspv_pkg::VCC_5V) ? 2'b01 : 2'b00;
    a = 2'b00;
    if (!sel) begin
      // code bit0 is line0; 10xx means line3 set -> 3.3 V
      case (aux)
        cspv_pkg::AUX_3V3: a = 2'b10;
        cspv_pkg::AUX_5V: a = 2'b01;
        cspv_pkg::AUX_1V8: a = 2'b11;
        cspv_pkg::AUX_HIZ: a = 2'b11;
        default: a = 2'b00;
      endcase
      if (vcc == cspv_pkg::VCC_OFF) begin
        cspv_enc = 4'h0;
      end else if (aux == cspv_pkg::AUX_HIZ) begin
        // supply-only codes: line0 and line1 both high, one core line picks the supply
        case (vcc)
          cspv_pkg::VCC_3V3: cspv_enc = 4'hB;
          cspv_pkg::VCC_5V: cspv_enc = 4'h7;
          default: cspv_enc = 4'hF;
        endcase
      end else begin
        cspv_enc = {a, v};
      end
    end else begin
      case (aux)
        cspv_pkg::AUX_12V: a = 2'b10;
        cspv_pkg::AUX_HIZ: a = 2'b11;
        cspv_pkg::AUX_VCC, cspv_pkg::AUX_3V3, cspv_pkg::AUX_5V: a = 2'b01;
        default: a = 2'b00;
      endcase
      cspv_enc = {a, v};
    end
  endfunction : cspv_enc

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ctl_q <= 4'h0;
    end else if (clk_en && tick) begin
      // updated only on the slow tick, from fully resolved request
      pwr_ctl_q <= cspv_enc(switch_type_select_q, eff_vcc, eff_aux);
    end
  end
  assign pwr_ctl = pwr_ctl_q;

  // ----------------------------------------------------------------
  // video pass-through pins
  // ----------------------------------------------------------------
  assign card_addr_o = card_addr_int;
  assign card_addr_oe = video_on ? 26'h000000F : 26'h3FFFFFF;
  assign video_select_n = !(video_on && !port_choice);
  assign video_path_status = video_on || port_choice;

  AST_SEL_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    !video_select_n |-> video_on) else $error("select low without video");
  AST_ADDR_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
    video_on |-> (card_addr_oe[25:4] == 22'h0 && card_addr_oe[3:0] == 4'hF)) else $error("address enables wrong");
  AST_LOW_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    card_addr_oe[3:0] == 4'hF) else $error("low address lines not driven");
  AST_STAT: assert property (@(posedge pclk) disable iff (!presetn)
    (!video_on && !port_choice) |-> (!video_path_status && video_select_n)) else $error("status wrong");
  AST_STAT_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (video_on && !port_choice) |-> (!video_select_n && video_path_status)) else $error("enabled outputs wrong");
  AST_PWR_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(tick) |-> $stable(pwr_ctl)) else $error("switch code changed off tick");
  AST_QDRV: assert property (@(posedge pclk) disable iff (!presetn)
    query_driver |-> query_lines_oe == 10'h000) else $error("query drive clash");
  AST_GND: assert property (@(posedge pclk) disable iff (!presetn)
    q_done_q |-> query_lines_oe == 10'h3FF) else $error("lines not grounded");
  AST_OFF7: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(tick) && !$past(switch_type_select_q) && $past(eff_vcc) == cspv_pkg::VCC_OFF) |-> pwr_ctl == 4'h0)
    else $error("off code wrong");
  AST_HIZ7: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(tick) && !$past(switch_type_select_q) && $past(eff_vcc) == cspv_pkg::VCC_3V3
    && $past(eff_aux) == cspv_pkg::AUX_HIZ) |-> pwr_ctl == 4'hB) else $error("supply only code wrong");
  AST_SUPPORT: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_en && paddr == cspv_pkg::ADDR_FORCE && pwdata[cspv_pkg::BIT_VSUPPORT]) |=> video_supported_q)
    else $error("supported bit not set");
  AST_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !pwrite && paddr == cspv_pkg::ADDR_SOCK_CTL) |=>
    prdata[cspv_pkg::BIT_VACTIVE] == ($past(card_video_passthru_enable_q) || $past(other_socket_video)
    || ($past(socket_video_enable_q) && !$past(video_model_disable_q)))) else $error("activity bit wrong");
  AST_STDMODEL: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !pwrite && paddr == cspv_pkg::ADDR_SOCK_CTL) |=>
    prdata[cspv_pkg::BIT_STDMODEL] == !$past(video_model_disable_q)) else $error("model bit wrong");
  AST_RST6: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !switch_type_select_q) else $error("table default wrong");
endmodule : cspv_ctl

// ### cspv_switch_model.sv
// adapter strap model seen by the query lines of the socket
`timescale 1ns/1ns
module cspv_switch_model (
  input wire logic query_driver, // query driver from the controller
  input wire logic [9:0] query_lines_o, // controller drive value
  input wire logic [9:0] query_lines_oe, // controller drive enable
  input wire logic [9:0] strap_ones, // lines strapped to the query driver
  output logic [9:0] query_lines // resolved line levels
);
  // ----------------------------------------------------------------
  // strap resolution
  // ----------------------------------------------------------------
  // a grounded controller driver wins over the strap
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      query_lines[i] = query_lines_oe[i] ? query_lines_o[i] : (strap_ones[i] ? query_driver : 1'b0);
    end
  end
endmodule : cspv_switch_model

// ### cspv_ctl_tb_top.sv
// self-checking testbench of the socket power and video control block
`timescale 1ns/1ns
module cspv_ctl_tb_top;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, query_driver;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic media_present_detect_n, port_choice, other_socket_video, video_path_status, video_select_n;
  logic [9:0] query_lines, query_lines_o, query_lines_oe, strap_ones;
  logic [3:0] pwr_ctl;
  logic [25:0] card_addr_o, card_addr_oe, card_addr_int;
  int n_fail, n_tests;

  cspv_ctl #(.OSC_DIV(2)) uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .media_present_detect_n(media_present_detect_n), .query_lines(query_lines), .query_driver(query_driver),
    .query_lines_o(query_lines_o), .query_lines_oe(query_lines_oe), .port_choice(port_choice),
    .other_socket_video(other_socket_video), .pwr_ctl(pwr_ctl), .card_addr_o(card_addr_o),
    .card_addr_oe(card_addr_oe), .card_addr_int(card_addr_int), .video_path_status(video_path_status),
    .video_select_n(video_select_n));

  cspv_switch_model partner (.query_driver(query_driver), .query_lines_o(query_lines_o),
    .query_lines_oe(query_lines_oe), .strap_ones(strap_ones), .query_lines(query_lines));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask : wr32

  task automatic rd_bit(input logic [7:0] a, input int b, input logic exp);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk({31'h0, rd[b]}, {31'h0, exp});
  endtask : rd_bit

  // polls the power outputs for a bounded time; slow ticks gate them
  task automatic pwr_expect(input logic [3:0] exp);
    for (int k = 0; k < 40 && pwr_ctl !== exp; k++) @(posedge pclk);
    chk({28'h0, pwr_ctl}, {28'h0, exp});
  endtask : pwr_expect

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic e;
    rd_bit(cspv_pkg::ADDR_GEN_CTL, cspv_pkg::BIT_SWSEL, 1'b0);
    chk({28'h0, pwr_ctl}, 32'h0);
    apb(1'b0, 8'hFC, 32'h0, e);
    chk({31'h0, e}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_reset

  // a card control write while the enable is low must leave that register untouched
  task automatic t_freeze;
    clk_en <= 1'b0;
    wr32(cspv_pkg::ADDR_CARD_CTL, 32'h1 << cspv_pkg::BIT_CARD_VIDEO);
    @(posedge pclk);
    chk({6'h0, card_addr_oe}, 32'h03FFFFFF);
    clk_en <= 1'b1;
  endtask : t_freeze

  task automatic t_video;
    wr32(cspv_pkg::ADDR_CARD_CTL, 32'h1 << cspv_pkg::BIT_CARD_VIDEO);
    @(posedge pclk);
    chk({6'h0, card_addr_oe}, 32'h0000000F);
    chk({6'h0, card_addr_o}, {6'h0, card_addr_int});
    chk({30'h0, video_select_n, video_path_status}, 32'h1);
    port_choice <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    chk({30'h0, video_select_n, video_path_status}, 32'h3);
    rd_bit(cspv_pkg::ADDR_SOCK_CTL, cspv_pkg::BIT_VACTIVE, 1'b1);
    port_choice <= 1'b0;
    wr32(cspv_pkg::ADDR_CARD_CTL, 32'h0);
    @(posedge pclk);
    chk({30'h0, video_select_n, video_path_status}, 32'h2);
    chk({6'h0, card_addr_oe}, 32'h03FFFFFF);
    other_socket_video <= 1'b1;
    rd_bit(cspv_pkg::ADDR_SOCK_CTL, cspv_pkg::BIT_VACTIVE, 1'b1);
    other_socket_video <= 1'b0;
    rd_bit(cspv_pkg::ADDR_SOCK_CTL, cspv_pkg::BIT_STDMODEL, 1'b1);
    wr32(cspv_pkg::ADDR_SOCK_CTL, 32'h1 << cspv_pkg::BIT_SOCK_VIDEO);
    @(posedge pclk);
    chk({31'h0, video_select_n}, 32'h0);
    wr32(cspv_pkg::ADDR_SOCK_CTL, 32'h0);
    wr32(cspv_pkg::ADDR_DIAG, 32'h1 << cspv_pkg::BIT_MODEL_DIS);
    wr32(cspv_pkg::ADDR_SOCK_CTL, 32'h1 << cspv_pkg::BIT_SOCK_VIDEO);
    @(posedge pclk);
    chk({31'h0, video_select_n}, 32'h1);
    rd_bit(cspv_pkg::ADDR_SOCK_CTL, cspv_pkg::BIT_STDMODEL, 1'b0);
    wr32(cspv_pkg::ADDR_DIAG, 32'h0);
  endtask : t_video

  task automatic t_force;
    rd_bit(cspv_pkg::ADDR_PRESENT, cspv_pkg::BIT_VSUPPORT, 1'b0);
    wr32(cspv_pkg::ADDR_FORCE, 32'h1 << cspv_pkg::BIT_VSUPPORT);
    rd_bit(cspv_pkg::ADDR_PRESENT, cspv_pkg::BIT_VSUPPORT, 1'b1);
  endtask : t_force

  // table rows: select, supply code, core code, expected lines 3..0
  task automatic t_power;
    logic [11:0] tbl [9] = '{{1'b0, 2'h1, 3'h3, 2'h0, 4'hE}, {1'b0, 2'h2, 3'h1, 2'h0, 4'h9},
      {1'b0, 2'h1, 3'h6, 2'h0, 4'hB}, {1'b0, 2'h2, 3'h6, 2'h0, 4'h7}, {1'b0, 2'h1, 3'h2, 2'h0, 4'h6},
      {1'b0, 2'h0, 3'h0, 2'h0, 4'h0}, {1'b1, 2'h2, 3'h4, 2'h0, 4'h9},
      {1'b1, 2'h1, 3'h5, 2'h0, 4'h6}, {1'b1, 2'h0, 3'h6, 2'h0, 4'hC}};
    for (int i = 0; i < 9; i++) begin
      wr32(cspv_pkg::ADDR_GEN_CTL, {21'h0, tbl[i][11], 10'h0});
      wr32(cspv_pkg::ADDR_PWR_REQ, {25'h0, tbl[i][8:6], 2'h0, tbl[i][10:9]});
      pwr_expect(tbl[i][3:0]);
    end
    wr32(cspv_pkg::ADDR_GEN_CTL, 32'h0);
  endtask : t_power

  task automatic t_query;
    logic e;
    strap_ones <= 10'h001;
    media_present_detect_n <= 1'b0;
    for (int k = 0; k < 10 && query_driver !== 1'b1; k++) @(posedge pclk);
    chk({31'h0, query_driver}, 32'h1);
    rd = 32'h0;
    for (int k = 0; k < 50 && rd[cspv_pkg::BIT_QDONE] !== 1'b1; k++) apb(1'b0, cspv_pkg::ADDR_QUERY, 32'h0, e);
    chk({22'h0, rd[9:0]}, 32'h1);
    chk({31'h0, query_driver}, 32'h0);
    chk({22'h0, query_lines_oe}, 32'h3FF);
    chk({22'h0, query_lines}, 32'h0);
    wr32(cspv_pkg::ADDR_PWR_REQ, {30'h0, cspv_pkg::VCC_5V});
    pwr_expect(4'h9);
    rd_bit(cspv_pkg::ADDR_QUERY, cspv_pkg::BIT_QOVR, 1'b1);
    media_present_detect_n <= 1'b1;
  endtask : t_query

  // a reset in mid-run must bring the first switch table back
  task automatic t_mid_reset;
    wr32(cspv_pkg::ADDR_GEN_CTL, 32'h1 << cspv_pkg::BIT_SWSEL);
    rd_bit(cspv_pkg::ADDR_GEN_CTL, cspv_pkg::BIT_SWSEL, 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({28'h0, pwr_ctl}, 32'h0);
    rd_bit(cspv_pkg::ADDR_GEN_CTL, cspv_pkg::BIT_SWSEL, 1'b0);
  endtask : t_mid_reset

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, port_choice, other_socket_video} = '0;
    clk_en = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    media_present_detect_n = 1'b1;
    strap_ones = 10'h000;
    card_addr_int = 26'h2A5A5A5;
    n_fail = 0;
    n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_freeze();
    t_video();
    t_force();
    t_power();
    t_query();
    t_mid_reset();
    wrap_up();
  end
endmodule : cspv_ctl_tb_top
